// file: design/spc_consts.svh
/*
  opcodes, frame lengths and self-timed durations of the sector protect command handler.
  assumes the includer defines nothing with the SPC_ prefix.
*/
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// instruction codes
`define SPC_OP_WR_EN 8'h06
`define SPC_OP_PROT_RD 8'hFC
`define SPC_OP_PROT_RD4 8'hE2
`define SPC_OP_PROT_PG 8'hFD
`define SPC_OP_PROT_PG4 8'hE3
`define SPC_OP_PROT_ER 8'hE4
`define SPC_OP_LCK_RD 8'hA7
`define SPC_OP_LCK_CLR 8'hA6
`define SPC_OP_PW_RD 8'hE7
`define SPC_OP_PW_PG 8'hE8

// frame lengths in serial clocks
`define SPC_LEN_OP 7'h08
`define SPC_LEN_A24 7'h20
`define SPC_LEN_A32 7'h28
`define SPC_LEN_PW 7'h48

// read values and reset values
`define SPC_PW_HIDDEN 64'hFFFF_FFFF_FFFF_FFFF
`define SPC_PW_RESET 64'hFFFF_FFFF_FFFF_FFFF
`define SPC_LOCK_RESET 1'h1

// self-timed durations, as times and as core clock cycles
`define SPC_CLK_NS 40
`define SPC_PROG_NS 2000
`define SPC_ERASE_NS 8000
`define SPC_PROG_CYC ((`SPC_PROG_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_ERASE_CYC ((`SPC_ERASE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

// file: design/spc_pkg.sv
/*
  types of the sector protect command handler: busy states and job kinds.
  assumes nothing beyond a SystemVerilog compiler.
*/
package spc_pkg;
  // one-hot busy state
  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_BUSY = 3'b010,
    SPC_FAIL = 3'b100
  } spc_state_t;

  // self-timed job in flight
  typedef enum logic [1:0] {
    SPC_JOB_PROG = 2'h0,
    SPC_JOB_ERASE = 2'h1,
    SPC_JOB_LOCK = 2'h2,
    SPC_JOB_PW = 2'h3
  } spc_job_t;
endpackage

// file: design/spc_sector_protect.sv
/*
  serial command handler for persistent sector protect bits, their lock bit and the password.
  assumes a host drives chip select, serial clock and serial in; all three are asynchronous
  to core_clk and at least four times slower; status and config bits are plain ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spc_consts.svh"

// Overview of operation
// R01 - read command returns sector's 8-bit protect value
// R02 - read repeats same value every eight clocks
// R03 - address top bit from length setting
// R04 - program accepted only with write-enable latch set
// R05 - program starts when select rises after address
// R06 - busy flag set, then cleared with latch
// R07 - program updates error and busy like array
// R08 - erase sets all protect bits, needs latch
// R09 - erase starts on select rise after opcode
// R10 - erase-suspend rejected while protect erase runs
// R11 - lock read repeats, only when idle
// R12 - host polls busy before next command
// R13 - lock clear zeroes lock bit, needs latch
// R14 - lock clear exact length, self-timed, clears latch
// R15 - password read 64 bits, low byte first
// R16 - password mode makes password read undefined
// R17 - password program needs write-enable latch
// R18 - password mode ignores password program
// R19 - password program needs exactly 64 data bits
// R20 - password program busy, error, then clears latch
// R21 - write commands without latch change nothing
// R22 - program sets addressed sector bit to zero
module spc_sector_protect #(
  parameter int NUM_SECTORS = 128,
  parameter int SEC_W = 7,
  parameter int PROG_CYC = `SPC_PROG_CYC,
  parameter int ERASE_CYC = `SPC_ERASE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic serial_in_io_zero,
  input wire logic addr_4byte_cfg,
  input wire logic pw_mode_off,
  input wire logic prog_fail,
  input wire logic clear_status,
  input wire logic erase_suspend_req,
  output logic serial_out_io_one,
  output logic serial_out_oe,
  output logic in_progress_flag,
  output logic write_enable_latch,
  output logic program_error,
  output logic prot_lock_bit,
  output logic suspend_reject
);
  import spc_pkg::*;

  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] PROG_LOAD = TMR_W'(PROG_CYC - 1);
  localparam logic [TMR_W-1:0] ERASE_LOAD = TMR_W'(ERASE_CYC - 1);

  // pin synchronisers; stage one feeds stage two only
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic si_s1_r, si_s2_r;

  // frame capture
  logic [6:0] cnt_r; // serial clocks seen, saturates
  logic [7:0] op_r; // instruction
  logic [63:0] sh_r; // address or password bits
  logic rd_act_r; // output phase running
  logic rd_pw_r; // output word is eight bytes wide
  logic [63:0] rd_word_r; // value being shifted out
  logic [5:0] idx_r; // output bit position

  // protection state
  logic [NUM_SECTORS-1:0] prot_bits_r; // one bit per sector, 0 = protected
  logic [63:0] pw_r;
  logic lock_r;

  // self-timed engine
  spc_state_t state_r;
  spc_job_t job_r;
  logic [TMR_W-1:0] tmr_r;
  logic [SEC_W-1:0] job_sec_r;
  logic [63:0] job_pw_r;
  logic wr_latch_r, busy_r, perr_r, sus_rej_r, so_r, oe_r;

  // reverse byte order so byte 0 lands in bits 7:0
  function automatic logic [63:0] byte_swap(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[8*b +: 8] = v[8*(7-b) +: 8];
    end
    return r;
  endfunction

  // header length in serial clocks for a given opcode
  function automatic logic [6:0] hdr_len(input logic [7:0] op, input logic a4);
    logic [6:0] n;
    n = `SPC_LEN_OP;
    if (op == `SPC_OP_PROT_RD || op == `SPC_OP_PROT_PG) begin
      n = a4 ? `SPC_LEN_A32 : `SPC_LEN_A24; // R03
    end else if (op == `SPC_OP_PROT_RD4 || op == `SPC_OP_PROT_PG4) begin
      n = `SPC_LEN_A32; // R03
    end else if (op == `SPC_OP_PW_PG) begin
      n = `SPC_LEN_PW;
    end
    return n;
  endfunction

  // edge and frame decode
  wire sck_rise = sck_s2_r & ~sck_s3_r;
  wire sck_fall = ~sck_s2_r & sck_s3_r;
  wire cs_rise = cs_s2_r & ~cs_s3_r;
  wire sel = ~cs_s2_r;
  wire [7:0] op_in = {op_r[6:0], si_s2_r};
  wire [63:0] sh_in = {sh_r[62:0], si_s2_r};
  wire [7:0] op_cur = (cnt_r < `SPC_LEN_OP) ? op_in : op_r;
  wire [6:0] cnt_inc = cnt_r + 7'h01;
  wire [6:0] op_len = hdr_len(op_r, addr_4byte_cfg);
  wire hdr_done = sel & sck_rise & (cnt_inc == hdr_len(op_cur, addr_4byte_cfg));
  wire idle = (state_r == SPC_IDLE);

  // opcode classes
  wire is_prot_rd = (op_cur == `SPC_OP_PROT_RD) | (op_cur == `SPC_OP_PROT_RD4);
  wire is_lck_rd = (op_cur == `SPC_OP_LCK_RD);
  wire is_pw_rd = (op_cur == `SPC_OP_PW_RD);
  wire is_read = is_prot_rd | is_lck_rd | is_pw_rd;
  wire is_pg = (op_r == `SPC_OP_PROT_PG) | (op_r == `SPC_OP_PROT_PG4);
  wire is_er = (op_r == `SPC_OP_PROT_ER);
  wire is_lclr = (op_r == `SPC_OP_LCK_CLR);
  wire is_pwpg = (op_r == `SPC_OP_PW_PG);
  wire is_write = is_pg | is_er | is_lclr | is_pwpg;

  // sector index: upper address bits beyond the array are ignored
  wire [SEC_W-1:0] rd_sec = sh_in[16 +: SEC_W]; // R03
  wire [SEC_W-1:0] pg_sec = sh_r[16 +: SEC_W];

  // a write starts only on exact length, idle engine and latch set
  wire len_ok = (cnt_r == op_len);
  wire go_ok = cs_rise & idle & wr_latch_r & len_ok; // R21
  wire start_pg = go_ok & is_pg; // R04 R05
  wire start_er = go_ok & is_er; // R08 R09
  wire start_lk = go_ok & is_lclr; // R13 R14
  wire start_pw = go_ok & is_pwpg & pw_mode_off; // R17 R18 R19
  wire start_any = start_pg | start_er | start_lk | start_pw;
  wire wr_en_hit = cs_rise & idle & (op_r == `SPC_OP_WR_EN) & (cnt_r == `SPC_LEN_OP);
  wire job_done = (state_r == SPC_BUSY) & (tmr_r == '0);

  // outgoing bit: byte from idx[5:3] for password, byte 0 otherwise
  wire [2:0] out_byte = rd_pw_r ? idx_r[5:3] : 3'h0;
  wire out_bit = rd_word_r[{out_byte, ~idx_r[2:0]}]; // R15

  // synchronisers
  always_ff @(posedge core_clk) begin
    sck_s1_r <= spi_sck;
    sck_s2_r <= sck_s1_r;
    sck_s3_r <= sck_s2_r;
    cs_s1_r <= spi_cs_n;
    cs_s2_r <= cs_s1_r;
    cs_s3_r <= cs_s2_r;
    si_s1_r <= serial_in_io_zero;
    si_s2_r <= si_s1_r;
  end

  // input shifting on rising serial clock
  always_ff @(posedge core_clk) begin
    if (sys_rst || !sel) begin
      cnt_r <= '0;
    end else if (sck_rise) begin
      if (cnt_r != 7'h7F) begin
        cnt_r <= cnt_inc;
      end
      if (cnt_r < `SPC_LEN_OP) begin
        op_r <= op_in;
      end else begin
        sh_r <= sh_in;
      end
    end
  end

  // output phase; the word is frozen once, so reads never advance
  always_ff @(posedge core_clk) begin
    if (sys_rst || !sel) begin
      rd_act_r <= 1'b0;
      oe_r <= 1'b0;
      so_r <= 1'b0;
      idx_r <= '0;
      rd_pw_r <= 1'b0;
      rd_word_r <= '0;
    end else begin
      if (hdr_done && is_read && idle) begin
        // lock read is only served with nothing in flight
        rd_act_r <= 1'b1; // R01 R11
        idx_r <= '0;
        rd_pw_r <= is_pw_rd;
        if (is_prot_rd) begin
          rd_word_r <= {56'h0, {8{prot_bits_r[rd_sec]}}}; // R01
        end else if (is_lck_rd) begin
          rd_word_r <= {63'h0, lock_r};
        end else begin
          rd_word_r <= pw_mode_off ? pw_r : `SPC_PW_HIDDEN; // R16
        end
      end
      if (rd_act_r && sck_fall) begin
        // 3-bit wrap for one byte, 6-bit wrap for the password
        so_r <= out_bit; // R02 R11 R15
        oe_r <= 1'b1;
        idx_r <= idx_r + 6'h01;
      end
    end
  end

  // self-timed engine
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= SPC_IDLE;
      job_r <= SPC_JOB_PROG;
      tmr_r <= '0;
      job_sec_r <= '0;
      job_pw_r <= '0;
      busy_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      unique case (state_r)
        SPC_IDLE: begin
          if (start_any) begin
            state_r <= SPC_BUSY;
            busy_r <= 1'b1; // R06 R14 R20
            job_sec_r <= pg_sec;
            job_pw_r <= byte_swap(sh_r); // R19
            tmr_r <= start_er ? ERASE_LOAD : PROG_LOAD;
            if (start_pg) job_r <= SPC_JOB_PROG;
            else if (start_er) job_r <= SPC_JOB_ERASE;
            else if (start_lk) job_r <= SPC_JOB_LOCK;
            else job_r <= SPC_JOB_PW;
          end
        end
        SPC_BUSY: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 16'h0001;
          end else if (prog_fail) begin
            // failure holds busy and error until status clear, like array programming
            state_r <= SPC_FAIL;
            perr_r <= 1'b1; // R07 R20
          end else begin
            state_r <= SPC_IDLE;
            busy_r <= 1'b0; // R06
          end
        end
        SPC_FAIL: begin
          if (clear_status) begin
            state_r <= SPC_IDLE;
            busy_r <= 1'b0;
            perr_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // protection contents change only on successful completion
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prot_bits_r <= '1;
      pw_r <= `SPC_PW_RESET;
      lock_r <= `SPC_LOCK_RESET;
    end else if (job_done && !prog_fail) begin
      unique case (job_r)
        SPC_JOB_PROG: prot_bits_r[job_sec_r] <= 1'b0; // R22
        SPC_JOB_ERASE: prot_bits_r <= '1; // R08
        SPC_JOB_LOCK: lock_r <= 1'b0; // R13
        SPC_JOB_PW: pw_r <= job_pw_r; // R20
      endcase
    end
  end

  // write-enable latch; completion clear wins, it never meets a set since the set needs idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_latch_r <= 1'b0;
    end else if (job_done && !prog_fail) begin
      wr_latch_r <= 1'b0; // R06 R14 R20
    end else if (wr_en_hit) begin
      wr_latch_r <= 1'b1;
    end
  end

  // suspend requests bounce off a running protect erase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sus_rej_r <= 1'b0;
    end else begin
      sus_rej_r <= erase_suspend_req && (state_r == SPC_BUSY) && (job_r == SPC_JOB_ERASE); // R10
    end
  end

  assign serial_out_io_one = so_r;
  assign serial_out_oe = oe_r;
  assign in_progress_flag = busy_r;
  assign write_enable_latch = wr_latch_r;
  assign program_error = perr_r;
  assign prot_lock_bit = lock_r;
  assign suspend_reject = sus_rej_r;

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_done_ok;
    job_done && !prog_fail;
  endsequence

  sequence s_cmd_no_latch;
    cs_rise && idle && !wr_latch_r && is_write;
  endsequence

  chk_prog_starts_busy: assert property (start_pg |=> in_progress_flag && state_r == SPC_BUSY) // R05
    else $error("program start did not raise busy");
  chk_no_latch_ignored: assert property (s_cmd_no_latch |=> state_r == SPC_IDLE && $stable(prot_bits_r)) // R21
    else $error("write without latch changed state");
  chk_done_clears: assert property (s_done_ok |=> !in_progress_flag && !write_enable_latch) // R06
    else $error("completion left busy or latch set");
  chk_sector_cleared: assert property (s_done_ok ##0 job_r == SPC_JOB_PROG |=> !prot_bits_r[job_sec_r]) // R22
    else $error("programmed sector bit not zero");
  chk_erase_all_ones: assert property (s_done_ok ##0 job_r == SPC_JOB_ERASE |=> &prot_bits_r) // R08
    else $error("erase left a zero bit");
  // a request in the erase's last cycle may legally see busy drop right after
  chk_suspend_reject: assert property (erase_suspend_req && state_r == SPC_BUSY && job_r == SPC_JOB_ERASE
    && !job_done |=> suspend_reject && in_progress_flag) // R10
    else $error("suspend not rejected during erase");
  chk_lock_cleared: assert property (s_done_ok ##0 job_r == SPC_JOB_LOCK |=> !prot_lock_bit) // R13
    else $error("lock bit not cleared");
  chk_pw_mode_ignores: assert property (cs_rise && idle && is_pwpg && !pw_mode_off
    |=> state_r == SPC_IDLE ##1 $stable(pw_r)) // R18
    else $error("password program ran in password mode");
  chk_fail_holds: assert property (job_done && prog_fail |=> program_error && in_progress_flag) // R07
    else $error("failure not reported");
  chk_busy_time: assert property (start_er |=> in_progress_flag [*8]) // R09
    else $error("erase busy dropped early");
  chk_read_drives: assert property (rd_act_r && sck_fall && sel |=> serial_out_oe) // R01
    else $error("read phase did not drive output");
endmodule
`default_nettype wire

// file: tb/spc_host_model.sv
/*
  host serial controller model: chip select, serial clock (320 ns) and serial data in.
  assumes core_clk comes from the bench; every pin change lands on its falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module spc_host_model (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic serial_in_io_zero,
  input wire logic serial_out_io_one,
  input wire logic serial_out_oe
);
  logic [63:0] rx; // bits read back, newest in bit 0
  logic saw_oe; // output enable seen at any sample point
  // idle: deselected, clock parked low
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    serial_in_io_zero = 1'b0;
  end
  // half a serial clock period is four core cycles
  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask
  // one frame: ntx bits msb first, then nrx bits read; unused address bits are sent as zero
  task automatic frame(input logic [71:0] tx, input int ntx, input int nrx);
    rx = '0;
    saw_oe = 1'b0;
    spi_cs_n = 1'b0;
    for (int i = ntx - 1; i >= 0; i--) begin
      serial_in_io_zero = tx[i];
      half();
      spi_sck = 1'b1;
      half();
      spi_sck = 1'b0;
    end
    // sample just before the rising edge, as a real host does
    for (int i = 0; i < nrx; i++) begin
      half();
      // an undriven output line floats to its pull-up
      rx = {rx[62:0], serial_out_oe ? serial_out_io_one : 1'b1};
      saw_oe = saw_oe | serial_out_oe;
      spi_sck = 1'b1;
      half();
      spi_sck = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    // released data line must not keep a stale level
    serial_in_io_zero = ~serial_in_io_zero;
    repeat (8) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  self-checking bench of the sector protect command handler.
  assumes spc_host_model as the host; a short program count and the default erase count are set at the instance.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk, sys_rst, addr_4byte_cfg, pw_mode_off, prog_fail, clear_status, erase_suspend_req;
  logic spi_cs_n, spi_sck, serial_in_io_zero; // driven by the host model
  logic serial_out_io_one, serial_out_oe, in_progress_flag, write_enable_latch;
  logic program_error, prot_lock_bit, suspend_reject;
  logic [6:0] outs; // status outputs packed for one compare
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0; // hang guard
  assign outs = {serial_out_io_one, serial_out_oe, in_progress_flag, write_enable_latch,
                 program_error, suspend_reject, prot_lock_bit};
  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // long erase keeps the device busy through a whole read frame
  spc_sector_protect #(.PROG_CYC(10), .ERASE_CYC(200)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .serial_in_io_zero(serial_in_io_zero),
    .addr_4byte_cfg(addr_4byte_cfg), .pw_mode_off(pw_mode_off), .prog_fail(prog_fail),
    .clear_status(clear_status), .erase_suspend_req(erase_suspend_req),
    .serial_out_io_one(serial_out_io_one), .serial_out_oe(serial_out_oe),
    .in_progress_flag(in_progress_flag), .write_enable_latch(write_enable_latch),
    .program_error(program_error), .prot_lock_bit(prot_lock_bit), .suspend_reject(suspend_reject));
  spc_host_model i_host (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .serial_in_io_zero(serial_in_io_zero), .serial_out_io_one(serial_out_io_one),
    .serial_out_oe(serial_out_oe));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // single compare for every kind of value
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hang guard, well above the roughly 9k cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic write_enable();
    i_host.frame(72'h06, 8, 0);
  endtask
  // bounded poll of the busy flag before the next command
  task automatic wait_idle();
    for (int i = 0; i < 400 && in_progress_flag !== 1'b0; i++) @(negedge core_clk);
    chk("busy flag", 64'h0, in_progress_flag);
  endtask
  // reads a sector's value for two bytes: the value must repeat
  task automatic rd_ppb(input logic [7:0] op, input logic [31:0] a, input int alen, input logic [7:0] exp);
    i_host.frame(alen == 32 ? {32'h0, op, a} : {40'h0, op, a[23:0]}, 8 + alen, 16);
    chk("protect value", {48'h0, exp, exp}, i_host.rx);
  endtask
  task automatic t_blank();
    chk("outputs after reset", 64'h01, outs);
    rd_ppb(8'hFC, 32'h0005_0000, 24, 8'hFF);
    addr_4byte_cfg = 1'b1;
    rd_ppb(8'hFC, 32'h0005_0000, 32, 8'hFF);
    addr_4byte_cfg = 1'b0;
    rd_ppb(8'hE2, 32'h0005_0000, 32, 8'hFF);
  endtask
  task automatic t_prog();
    i_host.frame({40'h0, 8'hFD, 24'h05_0000}, 32, 0);
    chk("program without latch", 64'h01, outs);
    write_enable();
    chk("latch", 64'h1, write_enable_latch);
    // one bit too many: dropped, latch kept
    i_host.frame({39'h0, 8'hFD, 24'h05_0000, 1'b0}, 33, 0);
    chk("overlong program", 64'h09, outs);
    i_host.frame({40'h0, 8'hFD, 24'h05_0000}, 32, 0);
    chk("busy", 64'h1, in_progress_flag);
    wait_idle();
    chk("done flags", 64'h01, outs);
    rd_ppb(8'hE2, 32'h0005_0000, 32, 8'h00);
    rd_ppb(8'hFC, 32'h0006_0000, 24, 8'hFF);
  endtask
  task automatic t_fail();
    prog_fail = 1'b1;
    write_enable();
    i_host.frame({32'h0, 8'hE3, 32'h0007_0000}, 40, 0);
    repeat (20) @(negedge core_clk);
    chk("failed job", 64'h7, {in_progress_flag, program_error, write_enable_latch});
    prog_fail = 1'b0;
    clear_status = 1'b1;
    @(negedge core_clk);
    clear_status = 1'b0;
    @(negedge core_clk);
    chk("cleared", 64'h0, {in_progress_flag, program_error});
    rd_ppb(8'hFC, 32'h0007_0000, 24, 8'hFF);
  endtask
  task automatic t_erase();
    logic seen;
    write_enable();
    i_host.frame(72'hE4, 8, 0);
    erase_suspend_req = 1'b1;
    @(negedge core_clk);
    erase_suspend_req = 1'b0;
    seen = suspend_reject;
    @(negedge core_clk);
    seen = seen | suspend_reject;
    chk("suspend refused", 64'h1, seen);
    chk("busy after suspend", 64'h1, in_progress_flag);
    // lock read while erasing gets no answer
    i_host.frame(72'hA7, 8, 8);
    chk("read while busy", 64'h0, i_host.saw_oe);
    chk("line released while busy", 64'hFF, i_host.rx);
    wait_idle();
    chk("latch after erase", 64'h0, write_enable_latch);
    rd_ppb(8'hFC, 32'h0005_0000, 24, 8'hFF);
  endtask
  task automatic t_lock();
    i_host.frame(72'hA7, 8, 16);
    chk("lock read", 64'h0101, i_host.rx);
    i_host.frame(72'hA6, 8, 0);
    chk("lock without latch", 64'h01, outs);
    write_enable();
    i_host.frame(72'hA6, 8, 0);
    chk("lock busy", 64'h1, in_progress_flag);
    wait_idle();
    chk("lock cleared", 64'h00, outs);
    i_host.frame(72'hA7, 8, 16);
    chk("lock read", 64'h0000, i_host.rx);
  endtask
  task automatic t_pw();
    i_host.frame(72'hE7, 8, 64);
    chk("blank password", 64'hFFFF_FFFF_FFFF_FFFF, i_host.rx);
    // password 8877665544332211, lowest byte sent first
    write_enable();
    i_host.frame({8'hE8, 64'h1122_3344_5566_7788}, 72, 0);
    chk("password busy", 64'h1, in_progress_flag);
    wait_idle();
    chk("password latch", 64'h0, write_enable_latch);
    i_host.frame(72'hE7, 8, 64);
    chk("password read", 64'h1122_3344_5566_7788, i_host.rx);
    pw_mode_off = 1'b0;
    i_host.frame(72'hE7, 8, 64);
    chk("hidden password", 64'hFFFF_FFFF_FFFF_FFFF, i_host.rx);
    write_enable();
    i_host.frame({8'hE8, 64'h0}, 72, 0);
    chk("ignored program", 64'h0, in_progress_flag);
    pw_mode_off = 1'b1;
    i_host.frame(72'hE7, 8, 64);
    chk("password kept", 64'h1122_3344_5566_7788, i_host.rx);
  endtask
  // reset for ten cycles, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    addr_4byte_cfg = 1'b0;
    pw_mode_off = 1'b1;
    prog_fail = 1'b0;
    clear_status = 1'b0;
    erase_suspend_req = 1'b0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_blank();
    t_prog();
    t_fail();
    t_erase();
    t_lock();
    t_pw();
    final_report();
  end
endmodule
`default_nettype wire
